// *** logic/sci_io_logic.sv ***
// sci_io_logic.sv: control connector logic of a pulse driven servo drive
// assumes one 200 MHz clock, synchronous reset and an apb master
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sci_consts.svh"

module sci_io_logic #(
    parameter int GEAR_W = 16,
    parameter int DIV_W  = 16,
    parameter int DEV_W  = 32
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // digital inputs, low when on
    input  wire logic        servoEnableInN,
    input  wire logic        alarmResetInN,
    input  wire logic        forwardDriveInhibitN,
    input  wire logic        reverseDriveInhibitN,
    input  wire logic        devClearInN,
    input  wire logic        pulseBlockInN,
    input  wire logic        gearRatioSelectN,
    // command pulse pair and motor encoder
    input  wire logic        commandPulseIn,
    input  wire logic        commandDirIn,
    input  wire logic        motorEncA,
    input  wire logic        motorEncB,
    input  wire logic        motorEncZ,
    // digital outputs
    output logic             positionReachedOut,
    output logic             brakeOut,
    output logic             faultFreeOut,
    output logic             indexPulseOut,
    output logic             motorPowerOut,
    // divided encoder feedback, index passed on undivided
    output logic             feedbackAOut,
    output logic             feedbackBOut,
    output logic             feedbackIndexOut,
    // interrupt
    output logic             irqOut
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`SCI_IN_N-1:0]  s1;
        logic [`SCI_IN_N-1:0]  s2;
        logic [`SCI_IN_N-1:0]  s3;
        logic [`SCI_IN_N-1:0]  flt;
        sci_pkg::sci_fmt_e     fmt;
        logic [GEAR_W-1:0]     gearPri;
        logic [GEAR_W-1:0]     gearAlt;
        logic [DEV_W-1:0]      inPosWin;
        logic [DEV_W-1:0]      devLimit;
        logic [DEV_W-1:0]      dev;
        logic [DIV_W-1:0]      divA;
        logic [DIV_W-1:0]      divB;
        logic [DIV_W:0]        fbAcc;
        logic [1:0]            fbGray;
        logic                  alarm;
        logic                  posReached;
        logic                  brake;
        logic                  faultFree;
        logic                  idx;
        logic [`SCI_IRQ_N-1:0] irqSt;
        logic [`SCI_IRQ_N-1:0] irqMask;
        logic [31:0]           rdata;
    } sci_state_s;

    sci_state_s            q;
    sci_state_s            d;
    logic [`SCI_IN_N-1:0]  rawPins, fltNext, rise, fall;
    logic                  run, devClr, alarmSet, inPos, fbStep;
    logic                  rawUp, rawDn, cmdUp, cmdDn, mUp, mDn;
    logic                  wrEn, rdSetup, rdDone, mapped;
    logic [GEAR_W-1:0]     gear;
    logic [DEV_W-1:0]      absDev;
    logic [DIV_W:0]        accSum;
    logic [31:0]           rdVal;
    logic [`SCI_IRQ_N-1:0] clrBits, events;

    // one step of a 4x quadrature decoder: {up, down}
    function automatic logic [1:0] quadStep(input logic oa, input logic ob,
                                            input logic na, input logic nb);
        logic moved;
        moved = (oa ^ na) ^ (ob ^ nb);
        quadStep = {moved & (ob ^ na), moved & ~(ob ^ na)};
    endfunction

    // ------------------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------------------
    // low level means on, an open input reads off
    assign rawPins = {motorEncZ, motorEncB, motorEncA, commandDirIn, commandPulseIn,
                      ~gearRatioSelectN, ~pulseBlockInN, ~devClearInN,
                      ~reverseDriveInhibitN, ~forwardDriveInhibitN,
                      ~alarmResetInN, ~servoEnableInN};

    // filtered level moves once stages two and three agree
    assign fltNext = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
    assign rise    = fltNext & ~q.flt;
    assign fall    = ~fltNext & q.flt;

    // ------------------------------------------------------------------------
    // command pulse decoding
    // ------------------------------------------------------------------------
    // format select, unknown code falls back to pulse and sign
    always_comb
    begin
        rawUp = 1'b0;
        rawDn = 1'b0;
        case (q.fmt)
            sci_pkg::SCI_FMT_FWD_REV:
            begin
                rawUp = rise[`SCI_IN_PUL];
                rawDn = rise[`SCI_IN_DIR];
            end
            sci_pkg::SCI_FMT_QUAD:
            begin
                {rawUp, rawDn} = quadStep(q.flt[`SCI_IN_PUL], q.flt[`SCI_IN_DIR],
                                          fltNext[`SCI_IN_PUL], fltNext[`SCI_IN_DIR]);
            end
            default:
            begin
                rawUp = rise[`SCI_IN_PUL] & q.flt[`SCI_IN_DIR];
                rawDn = rise[`SCI_IN_PUL] & ~q.flt[`SCI_IN_DIR];
            end
        endcase
    end

    // enable and no alarm lets the drive work
    assign run = q.flt[`SCI_IN_ENA] & ~q.alarm;

    // block, direction inhibits, opposite steps cancel
    assign cmdUp = run & ~q.flt[`SCI_IN_BLK] & rawUp & ~rawDn & ~q.flt[`SCI_IN_FWD];
    assign cmdDn = run & ~q.flt[`SCI_IN_BLK] & rawDn & ~rawUp & ~q.flt[`SCI_IN_REV];

    // motor encoder counts
    assign {mUp, mDn} = quadStep(q.flt[`SCI_IN_MA], q.flt[`SCI_IN_MB],
                                 fltNext[`SCI_IN_MA], fltNext[`SCI_IN_MB]);

    // ------------------------------------------------------------------------
    // deviation counter
    // ------------------------------------------------------------------------
    // ratio choice
    assign gear   = q.flt[`SCI_IN_GSEL] ? q.gearAlt : q.gearPri;
    assign devClr = q.flt[`SCI_IN_CLR] | ~q.flt[`SCI_IN_ENA];
    assign absDev = q.dev[DEV_W-1] ? DEV_W'(-q.dev) : q.dev;

    // overrun latches the alarm, window sets position reached
    assign alarmSet = run & (absDev > q.devLimit);
    assign inPos    = run & (absDev <= q.inPosWin);

    // ------------------------------------------------------------------------
    // feedback divider
    // ------------------------------------------------------------------------
    // fraction a over b of motor counts becomes output steps
    assign accSum = q.fbAcc + (DIV_W+1)'(q.divA);
    assign fbStep = (mUp | mDn) & (q.divB != '0) & (accSum >= {1'b0, q.divB});

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    // zero wait, read data caught in the setup cycle
    assign wrEn    = psel & penable & pwrite;
    assign rdSetup = psel & ~penable & ~pwrite;
    assign rdDone  = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = q.rdata;

    // read mux and address decode
    always_comb
    begin
        rdVal  = '0;
        mapped = 1'b1;
        case (paddr)
            `SCI_OFS_CTRL:      rdVal = 32'(q.fmt);
            `SCI_OFS_GEAR_PRI:  rdVal = 32'(q.gearPri);
            `SCI_OFS_GEAR_ALT:  rdVal = 32'(q.gearAlt);
            `SCI_OFS_INPOS:     rdVal = 32'(q.inPosWin);
            `SCI_OFS_FBDIV_A:   rdVal = 32'(q.divA);
            `SCI_OFS_FBDIV_B:   rdVal = 32'(q.divB);
            `SCI_OFS_DEVLIM:    rdVal = 32'(q.devLimit);
            `SCI_OFS_DEVIATION: rdVal = 32'(q.dev);
            `SCI_OFS_IRQ_STAT:  rdVal = 32'(q.irqSt);
            `SCI_OFS_IRQ_MASK:  rdVal = 32'(q.irqMask);
            `SCI_OFS_STATUS:
            begin
                rdVal[`SCI_IN_N-1:0] = q.flt;
                rdVal[`SCI_ST_ALARM] = q.alarm;
                rdVal[`SCI_ST_INPOS] = q.posReached;
                rdVal[`SCI_ST_BRAKE] = q.brake;
                rdVal[`SCI_ST_POWER] = run;
            end
            default:            mapped = 1'b0;
        endcase
    end

    // only bits shown by the read are cleared, so new events survive
    assign clrBits = (rdDone && paddr == `SCI_OFS_IRQ_STAT) ? q.rdata[`SCI_IRQ_N-1:0] : '0;
    assign events  = {rise[`SCI_IN_MZ], inPos & ~q.posReached, alarmSet & ~q.alarm};

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        d      = q;
        d.s1   = rawPins;
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.flt  = fltNext;
        // register writes take effect at the access edge
        if (wrEn)
        begin
            case (paddr)
                `SCI_OFS_CTRL:
                    d.fmt = sci_pkg::sci_fmt_e'(pwdata[`SCI_CTRL_FMT_MSB:`SCI_CTRL_FMT_LSB]);
                `SCI_OFS_GEAR_PRI: d.gearPri  = pwdata[GEAR_W-1:0];
                `SCI_OFS_GEAR_ALT: d.gearAlt  = pwdata[GEAR_W-1:0];
                `SCI_OFS_INPOS:    d.inPosWin = pwdata[DEV_W-1:0];
                `SCI_OFS_FBDIV_A:  d.divA     = pwdata[DIV_W-1:0];
                `SCI_OFS_FBDIV_B:  d.divB     = pwdata[DIV_W-1:0];
                `SCI_OFS_DEVLIM:   d.devLimit = pwdata[DEV_W-1:0];
                `SCI_OFS_IRQ_MASK: d.irqMask  = pwdata[`SCI_IRQ_N-1:0];
                default:           d.irqMask  = q.irqMask;
            endcase
        end
        // clear wins, else geared commands minus motor counts
        if (devClr)
            d.dev = '0;
        else
            d.dev = q.dev + (cmdUp ? DEV_W'(gear) : '0) - (cmdDn ? DEV_W'(gear) : '0)
                  - DEV_W'(mUp) + DEV_W'(mDn);
        // alarm set beats the clear on the off edge
        d.alarm = alarmSet | (q.alarm & ~fall[`SCI_IN_ACLR]);
        // registered output levels
        d.posReached = inPos;
        d.faultFree  = ~q.alarm;
        d.idx        = q.flt[`SCI_IN_MZ];
        // brake released only in clean enabled operation
        d.brake = q.flt[`SCI_IN_ENA] & ~q.alarm & ~q.flt[`SCI_IN_FWD] & ~q.flt[`SCI_IN_REV];
        // feedback accumulator and gray step
        if (mUp | mDn)
            d.fbAcc = fbStep ? accSum - {1'b0, q.divB} : accSum;
        if (fbStep)
        begin
            d.fbGray = mUp ? q.fbGray ^ (q.fbGray[1] ^ q.fbGray[0] ? 2'h2 : 2'h1)
                           : q.fbGray ^ (q.fbGray[1] ^ q.fbGray[0] ? 2'h1 : 2'h2);
        end
        // sticky events, set wins over a read clear
        d.irqSt = (q.irqSt & ~clrBits) | events;
        if (rdSetup)
            d.rdata = rdVal;
    end

    // state register with synchronous reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q           <= '0;
            q.gearPri   <= GEAR_W'(`SCI_RST_GEAR);
            q.gearAlt   <= GEAR_W'(`SCI_RST_GEAR);
            q.inPosWin  <= DEV_W'(`SCI_RST_INPOS);
            q.devLimit  <= DEV_W'(`SCI_RST_DEVLIM);
            q.divA      <= DIV_W'(`SCI_RST_FBDIV);
            q.divB      <= DIV_W'(`SCI_RST_FBDIV);
            q.faultFree <= 1'b1;
        end
        else
            q <= d;
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign positionReachedOut = q.posReached;
    assign brakeOut           = q.brake;
    assign faultFreeOut       = q.faultFree;
    assign indexPulseOut      = q.idx;
    assign feedbackIndexOut   = q.idx;
    assign feedbackAOut       = q.fbGray[1];
    assign feedbackBOut       = q.fbGray[0];
    assign motorPowerOut      = run;
    assign irqOut             = |(q.irqSt & q.irqMask);

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_enable_off_power: assert property (
        !q.flt[`SCI_IN_ENA] |-> !motorPowerOut && !cmdUp && !cmdDn)
        else $error("motor powered while disabled");
    chk_alarm_clear_edge: assert property (
        q.alarm && fall[`SCI_IN_ACLR] && !alarmSet |=> !q.alarm ##1 faultFreeOut)
        else $error("alarm not cleared by clear input");
    chk_fwd_inhibit: assert property (
        q.flt[`SCI_IN_FWD] |-> !cmdUp)
        else $error("forward step while inhibited");
    chk_rev_inhibit: assert property (
        q.flt[`SCI_IN_REV] |-> !cmdDn)
        else $error("reverse step while inhibited");
    chk_dev_clear: assert property (
        q.flt[`SCI_IN_CLR] |=> q.dev == '0)
        else $error("deviation not cleared");
    chk_pulse_block: assert property (
        q.flt[`SCI_IN_BLK] |-> !cmdUp && !cmdDn)
        else $error("command step while blocked");
    chk_gear_scale: assert property (
        cmdUp && !mUp && !mDn && !devClr
        |=> q.dev == $past(q.dev) + DEV_W'($past(q.flt[`SCI_IN_GSEL]) ? $past(q.gearAlt)
                                                                : $past(q.gearPri)))
        else $error("deviation step not scaled by chosen gear");
    chk_in_position: assert property (
        run && absDev <= q.inPosWin |=> positionReachedOut)
        else $error("position reached missing");
    chk_brake_alarm: assert property (
        q.alarm |=> !brakeOut)
        else $error("brake on during alarm");
    chk_fault_out: assert property (
        $rose(q.alarm) |=> !faultFreeOut)
        else $error("fault free still on after alarm");
    chk_index_out: assert property (
        q.flt[`SCI_IN_MZ] |=> indexPulseOut && feedbackIndexOut)
        else $error("index output missing");
    chk_quad_single: assert property (
        !fbStep |=> $stable(q.fbGray))
        else $error("feedback moved without a step");

endmodule
`default_nettype wire

// *** logic/sci_consts.svh ***
// sci_consts.svh: offsets, bit positions and reset values of the servo io block
// assumes inclusion by bare name from the design module and the testbench
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------------------
`define SCI_OFS_CTRL      8'h00
`define SCI_OFS_GEAR_PRI  8'h04
`define SCI_OFS_GEAR_ALT  8'h08
`define SCI_OFS_INPOS     8'h0C
`define SCI_OFS_FBDIV_A   8'h10
`define SCI_OFS_FBDIV_B   8'h14
`define SCI_OFS_DEVLIM    8'h18
`define SCI_OFS_STATUS    8'h1C
`define SCI_OFS_DEVIATION 8'h20
`define SCI_OFS_IRQ_STAT  8'h24
`define SCI_OFS_IRQ_MASK  8'h28

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SCI_CTRL_FMT_MSB  1
`define SCI_CTRL_FMT_LSB  0
`define SCI_IN_ENA        0
`define SCI_IN_ACLR       1
`define SCI_IN_FWD        2
`define SCI_IN_REV        3
`define SCI_IN_CLR        4
`define SCI_IN_BLK        5
`define SCI_IN_GSEL       6
`define SCI_IN_PUL        7
`define SCI_IN_DIR        8
`define SCI_IN_MA         9
`define SCI_IN_MB         10
`define SCI_IN_MZ         11
`define SCI_IN_N          12
`define SCI_ST_ALARM      12
`define SCI_ST_INPOS      13
`define SCI_ST_BRAKE      14
`define SCI_ST_POWER      15
`define SCI_IRQ_ALARM     0
`define SCI_IRQ_INPOS     1
`define SCI_IRQ_INDEX     2
`define SCI_IRQ_N         3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SCI_RST_GEAR      1
`define SCI_RST_INPOS     10
`define SCI_RST_FBDIV     1
`define SCI_RST_DEVLIM    65536

`endif

// *** logic/sci_pkg.sv ***
// sci_pkg.sv: types shared by the servo io block
// assumes nothing from sci_consts.svh, which it does not include
package sci_pkg;
    // command pulse formats, codes 0, 1, 2
    typedef enum logic [1:0] {
        SCI_FMT_PULSE_DIR,
        SCI_FMT_FWD_REV,
        SCI_FMT_QUAD
    } sci_fmt_e;
endpackage

// *** testbench/sci_host_model.sv ***
// sci_host_model.sv: host controller model driving the command pulse pair
// assumes step() is called by the bench just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module sci_host_model (
    // clock
    input  wire logic       clk,
    // selected format and command pins
    input  wire logic [1:0] fmt,
    output logic            pulseOut,
    output logic            dirOut
);
    int ph = 0;

    // both lines idle low between pulse steps, quadrature holds its last phase
    initial {pulseOut, dirOut} = 2'h0;

    // hold each level five cycles, longer than the input filter needs
    task automatic hold(input logic p, input logic d);
        pulseOut <= p;
        dirOut   <= d;
        repeat (5) @(posedge clk);
    endtask

    // one command step in the format the host was told to use
    task automatic step(input logic fwd);
        logic [1:0] seq [4];
        seq = '{2'h0, 2'h2, 2'h3, 2'h1};
        if (fmt == 2'h2)
        begin
            ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4; // pulse leads dir going forward
            hold(seq[ph][1], seq[ph][0]);
        end
        else if (fmt == 2'h1)
        begin
            hold(fwd, !fwd); // forward on pulse, reverse on dir
            hold(1'b0, 1'b0);
        end
        else
        begin
            hold(1'b0, fwd); // sign set up before the pulse edge
            hold(1'b1, fwd);
            hold(1'b0, fwd);
            hold(1'b0, 1'b0);
        end
    endtask
endmodule

`default_nettype wire

// *** testbench/test_servo_control_io_logic.sv ***
// test_servo_control_io_logic.sv: self-checking bench of the servo io block
// assumes sci_host_model drives the command pins; reads and pin samples are scored
`timescale 1ns/1ps
`default_nettype none
`include "sci_consts.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module test_servo_control_io_logic;
    // ------------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------------
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pinChk = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, pulseIn, dirIn;
    logic [6:0]  pinsN = 7'h7F; // {gsel,blk,clr,rev,fwd,aclr,ena}, open is off
    logic [2:0]  enc = 3'h0;    // {z,a,b}
    logic [8:0]  outs;          // {irq,fbz,z,pow,ok,brk,inpos,fba,fbb}
    logic [1:0]  fmt = 2'h0;
    logic [32:0] apbQ [$], e;
    logic [17:0] pinQ [$], p;
    int          errors = 0, compares = 0, dev = 0, g0, g1, mph = 0;

    sci_io_logic sci_io_logic_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servoEnableInN(pinsN[0]), .alarmResetInN(pinsN[1]), .forwardDriveInhibitN(pinsN[2]),
        .reverseDriveInhibitN(pinsN[3]), .devClearInN(pinsN[4]), .pulseBlockInN(pinsN[5]),
        .gearRatioSelectN(pinsN[6]), .commandPulseIn(pulseIn), .commandDirIn(dirIn),
        .motorEncA(enc[1]), .motorEncB(enc[0]), .motorEncZ(enc[2]),
        .positionReachedOut(outs[2]), .brakeOut(outs[3]), .faultFreeOut(outs[4]),
        .indexPulseOut(outs[6]), .motorPowerOut(outs[5]), .feedbackAOut(outs[1]),
        .feedbackBOut(outs[0]), .feedbackIndexOut(outs[7]), .irqOut(outs[8]));
    sci_host_model sci_host_model_inst (.clk(clk), .fmt(fmt), .pulseOut(pulseIn), .dirOut(dirIn));

    // 200 MHz clock
    initial forever #2.5 clk = ~clk;

    // scoreboard: oldest note against each finished read or pin sample
    always @(posedge clk)
    begin
        if (psel && penable && pready && !pwrite && apbQ.size() != 0)
        begin
            e = apbQ.pop_front();
            `CHK("apb read", e, {pslverr, prdata})
        end
        if (pinChk)
        begin
            p = pinQ.pop_front();
            `CHK("pins", p[8:0], outs & p[17:9])
        end
    end

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        {psel, penable} <= 2'h0;
        if (n == 20)
        begin
            errors++;
            close_out();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] ex);
        apbQ.push_back(ex);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pins(input logic [8:0] ex, input logic [8:0] m);
        pinQ.push_back({m, ex & m});
        pinChk <= 1'b1;
        @(posedge clk);
        pinChk <= 1'b0;
    endtask

    task automatic pin(input int i, input logic on);
        pinsN[i] <= !on;
        wt(8);
    endtask

    // host steps, then the deviation read back
    task automatic cmd(input int nf, input int nr, input int gf, input int gr);
        repeat (nf) sci_host_model_inst.step(1'b1);
        repeat (nr) sci_host_model_inst.step(1'b0);
        dev += nf * gf - nr * gr;
        wt(6);
        rd(`SCI_OFS_DEVIATION, {1'b0, 32'(dev)});
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        static logic [7:0]  ra [8] = '{`SCI_OFS_CTRL, `SCI_OFS_GEAR_PRI, `SCI_OFS_GEAR_ALT,
            `SCI_OFS_INPOS, `SCI_OFS_FBDIV_A, `SCI_OFS_FBDIV_B, `SCI_OFS_DEVLIM, `SCI_OFS_IRQ_MASK};
        static logic [31:0] rv [8] = '{32'h0, `SCI_RST_GEAR, `SCI_RST_GEAR, `SCI_RST_INPOS,
            `SCI_RST_FBDIV, `SCI_RST_FBDIV, `SCI_RST_DEVLIM, 32'h0};
        void'($urandom(32'hB989));
        g0 = 3 + $urandom % 5;
        g1 = 2 + $urandom % 6;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        pin(0, 1'b1);
        for (int i = 0; i < 8; i++) rd(ra[i], {1'b0, rv[i]});
        rd(8'h30, {1'b1, 32'h0});
        pins(9'h03C, 9'h1FF);
        apb(1'b1, `SCI_OFS_GEAR_PRI, 32'(g0));
        apb(1'b1, `SCI_OFS_GEAR_ALT, 32'(g1));
        for (int f = 0; f < 3; f++)
        begin
            apb(1'b1, `SCI_OFS_CTRL, 32'(f));
            fmt <= f[1:0];
            pin(6, 1'b0);
            cmd(3, 1, g0, g0);
            pin(6, 1'b1);
            cmd(1, 0, g1, g1);
        end
        pin(6, 1'b0);
        pin(5, 1'b1);
        cmd(2, 0, 0, 0);
        pin(5, 1'b0);
        pin(2, 1'b1);
        pins(9'h000, 9'h008);
        cmd(1, 1, 0, g0);
        pin(2, 1'b0);
        pin(3, 1'b1);
        cmd(1, 1, g0, 0);
        pin(3, 1'b0);
        // motor moves two counts forward, then shows its index
        for (int k = 0; k < 2; k++)
        begin
            mph = (mph + 1) % 4;
            enc[1:0] <= (mph == 1) ? 2'h2 : 2'h3;
            wt(5);
        end
        dev -= 2; // two forward motor counts come off the deviation
        cmd(0, 0, 0, 0);
        rd(`SCI_OFS_DEVIATION, {1'b0, 32'(dev)});
        pins(9'h003, 9'h003);
        enc[2] <= 1'b1;
        wt(8);
        pins(9'h0C0, 9'h0C0);
        enc[2] <= 1'b0;
        pin(4, 1'b1);
        dev = 0;
        rd(`SCI_OFS_DEVIATION, 33'h0);
        pin(4, 1'b0);
        // deviation alarm, masked then unmasked interrupt
        apb(1'b0, `SCI_OFS_IRQ_STAT, 32'h0);
        apb(1'b1, `SCI_OFS_DEVLIM, 32'h2);
        cmd(1, 0, g0, g0);
        pins(9'h000, 9'h138);
        apb(1'b1, `SCI_OFS_IRQ_MASK, 32'h1);
        pins(9'h100, 9'h100);
        rd(`SCI_OFS_IRQ_STAT, {1'b0, 32'h1});
        rd(`SCI_OFS_IRQ_STAT, 33'h0);
        pins(9'h000, 9'h100);
        pin(4, 1'b1);
        pin(1, 1'b1);
        pin(1, 1'b0);
        pins(9'h010, 9'h010);
        pin(4, 1'b0);
        pin(0, 1'b0);
        pins(9'h000, 9'h028);
        close_out();
    end

    // watchdog for any hang outside the bus waits
    initial
    begin
        wt(100000);
        errors++;
        close_out();
    end
endmodule

`default_nettype wire
